// *** design/irz_axis.sv ***
// One axis of the zoom window: holds the current size and moves it by
// one step, clamped between a minimum and full resolution.
// Assumes step_en is a single-cycle pulse, at most one per frame.
`default_nettype none
module irz_axis #(
	parameter logic [10:0] FULL = irz_pkg::FULL_W_RST,
	parameter logic [10:0] MIN = irz_pkg::MIN_W_RST
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic step_en,
	input wire logic dir_out,
	input wire logic [7:0] step,
	output logic [10:0] size_ff,
	output logic at_full,
	output logic hit_limit
);
	initial begin
		if (MIN > FULL || MIN == 11'h000)
			$error("irz_axis: MIN must be nonzero and not above FULL");
	end

	////////////////////////////////////////////////////////////////////
	wire logic [11:0] grow = {1'b0, size_ff} + {4'h0, step};
	wire logic [11:0] floor_plus = {1'b0, MIN} + {4'h0, step};
	wire logic [10:0] up_val = (grow >= {1'b0, FULL}) ? FULL : grow[10:0];
	// Clamp before subtracting so the size never wraps below the minimum
	wire logic [10:0] dn_val = ({1'b0, size_ff} <= floor_plus) ? MIN :
		11'(size_ff - {3'h0, step});
	wire logic [10:0] nxt_size = dir_out ? up_val : dn_val;

	assign at_full = (size_ff == FULL);
	assign hit_limit = dir_out ? (nxt_size == FULL) : (nxt_size == MIN);

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			size_ff <= FULL;
		else if (step_en)
			size_ff <= nxt_size;
	end
endmodule
`default_nettype wire

// *** design/irz_pkg.sv ***
// Package for the image reducer auto zoom block: register map, reset
// values, field positions and the zoom state encoding.
// Assumes a 16-bit register port on the image flow processor page.
`default_nettype none
package irz_pkg;
	localparam logic [8:0] ADDR_CUR_W = 9'h1AB;
	localparam logic [8:0] ADDR_CUR_H = 9'h1AC;
	localparam logic [8:0] ADDR_STEP = 9'h1AE;
	localparam logic [8:0] ADDR_CTRL = 9'h1AF;
	localparam logic [15:0] STEP_RST = 16'h0504;
	localparam logic [15:0] CTRL_RST = 16'h0010;
	// Writable control bits: 9, 8, 6, 5, 4, 3
	localparam logic [15:0] CTRL_WMASK = 16'h0378;
	localparam int STEP_X_LSB = 8;
	localparam int STEP_Y_LSB = 0;
	localparam int CTRL_OUT_BIT = 9;
	localparam int CTRL_IN_BIT = 8;
	localparam int CTRL_CLASSIC_BIT = 3;
	localparam int SIZE_W = 11;
	localparam logic [10:0] FULL_W_RST = 11'h500;
	localparam logic [10:0] FULL_H_RST = 11'h400;
	localparam logic [10:0] MIN_W_RST = 11'h028;
	localparam logic [10:0] MIN_H_RST = 11'h020;
	typedef enum logic [1:0] {
		IRZ_IDLE,
		IRZ_ZOOM_IN,
		IRZ_ZOOM_OUT
	} irz_state_t;
endpackage
`default_nettype wire

// *** design/irz_zoom.sv ***
// Automatic zoom control of the image reducer: step register, control
// register, current window size readback and classic interpolation.
// Assumes a pixel-clock register port and a one-cycle frame start pulse.
`default_nettype none
module irz_zoom #(
	parameter logic [10:0] FULL_W = irz_pkg::FULL_W_RST,
	parameter logic [10:0] FULL_H = irz_pkg::FULL_H_RST,
	parameter logic [10:0] MIN_W = irz_pkg::MIN_W_RST,
	parameter logic [10:0] MIN_H = irz_pkg::MIN_H_RST
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic frame_start,
	input wire logic [8:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata_ff,
	output logic [10:0] zoom_width,
	output logic [10:0] zoom_height,
	output logic [2:0] interp_mode,
	output logic classic_interp,
	output logic zoom_busy
);
	initial begin
		if (FULL_W == 11'h000 || FULL_H == 11'h000)
			$error("irz_zoom: full resolution must be nonzero");
	end

	////////////////////////////////////////////////////////////////////
	// Register file
	logic [15:0] step_ff;
	logic [15:0] ctrl_ff;
	irz_pkg::irz_state_t state_ff;
	irz_pkg::irz_state_t nxt_state;
	logic [1:0] hit;
	logic [1:0] full;

	wire logic wr_step = reg_wr && (reg_addr == irz_pkg::ADDR_STEP);
	wire logic wr_ctrl = reg_wr && (reg_addr == irz_pkg::ADDR_CTRL);
	wire logic step_now = frame_start && (state_ff != irz_pkg::IRZ_IDLE);
	wire logic going_out = (state_ff == irz_pkg::IRZ_ZOOM_OUT);

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			step_ff <= irz_pkg::STEP_RST;
		else if (wr_step)
			step_ff <= reg_wdata;
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			ctrl_ff <= irz_pkg::CTRL_RST;
		else if (wr_ctrl)
			ctrl_ff <= reg_wdata & irz_pkg::CTRL_WMASK;
	end

	////////////////////////////////////////////////////////////////////
	// Zoom sequencer; a software write overrides a same-cycle stop
	always_comb begin
		nxt_state = state_ff;
		if (wr_ctrl) begin
			if (reg_wdata[irz_pkg::CTRL_OUT_BIT])
				nxt_state = irz_pkg::IRZ_ZOOM_OUT;
			else if (reg_wdata[irz_pkg::CTRL_IN_BIT])
				nxt_state = irz_pkg::IRZ_ZOOM_IN;
			else
				nxt_state = irz_pkg::IRZ_IDLE;
		end else begin
			case (state_ff)
				irz_pkg::IRZ_ZOOM_IN, irz_pkg::IRZ_ZOOM_OUT: begin
					if (step_now && (hit != 2'h0))
						nxt_state = irz_pkg::IRZ_IDLE;
				end
				default: nxt_state = irz_pkg::IRZ_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			state_ff <= irz_pkg::IRZ_IDLE;
		else
			state_ff <= nxt_state;
	end

	////////////////////////////////////////////////////////////////////
	// Window axes, X then Y
	// one step per frame
	irz_axis #(
		.FULL(FULL_W),
		.MIN(MIN_W)
	) u_axis_x (
		.clk(clk),
		.sys_rst(sys_rst),
		.step_en(step_now),
		.dir_out(going_out),
		.step(step_ff[irz_pkg::STEP_X_LSB +: 8]),
		.size_ff(zoom_width),
		.at_full(full[0]),
		.hit_limit(hit[0])
	);

	irz_axis #(
		.FULL(FULL_H),
		.MIN(MIN_H)
	) u_axis_y (
		.clk(clk),
		.sys_rst(sys_rst),
		.step_en(step_now),
		.dir_out(going_out),
		.step(step_ff[irz_pkg::STEP_Y_LSB +: 8]),
		.size_ff(zoom_height),
		.at_full(full[1]),
		.hit_limit(hit[1])
	);

	////////////////////////////////////////////////////////////////////
	// Outputs and readback
	// classic at full resolution
	assign classic_interp = ctrl_ff[irz_pkg::CTRL_CLASSIC_BIT] &&
		(full == 2'h3);
	assign interp_mode = ctrl_ff[6:4];
	assign zoom_busy = (state_ff != irz_pkg::IRZ_IDLE);

	// Start bits show the live sequencer, so they self-clear when done
	wire logic [15:0] ctrl_view = {ctrl_ff[15:10], going_out,
		(state_ff == irz_pkg::IRZ_ZOOM_IN), ctrl_ff[7:0]};
	logic [15:0] rd_mux;

	always_comb begin
		if (reg_addr == irz_pkg::ADDR_CUR_W)
			rd_mux = {5'h00, zoom_width};
		else if (reg_addr == irz_pkg::ADDR_CUR_H)
			rd_mux = {5'h00, zoom_height};
		else if (reg_addr == irz_pkg::ADDR_STEP)
			rd_mux = step_ff;
		else if (reg_addr == irz_pkg::ADDR_CTRL)
			rd_mux = ctrl_view;
		else
			rd_mux = 16'h0000;
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			reg_rdata_ff <= 16'h0000;
		else if (reg_rd)
			reg_rdata_ff <= rd_mux;
	end
endmodule
`default_nettype wire

// *** sim/irz_zoom_assertions.sv ***
// Checker for the auto zoom block ports.
// Assumes a bind from the bench top file.
`default_nettype none
module irz_zoom_assertions #(
	parameter logic [10:0] FULL_W = irz_pkg::FULL_W_RST,
	parameter logic [10:0] FULL_H = irz_pkg::FULL_H_RST
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic frame_start,
	input wire logic [8:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata_ff,
	input wire logic [10:0] zoom_width,
	input wire logic [10:0] zoom_height,
	input wire logic classic_interp,
	input wire logic zoom_busy
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence s_ctl_wr(b);
		reg_wr && reg_addr == 9'h1AF && reg_wdata[b];
	endsequence
	sequence s_rd(a);
		reg_rd && reg_addr == a;
	endsequence
	property p_out;
		s_ctl_wr(9) |=> zoom_busy;
	endproperty
	property p_in;
		s_ctl_wr(8) |=> zoom_busy;
	endproperty
	property p_rsv;
		s_rd(9'h1AF) |=> reg_rdata_ff[1:0] == 2'h0;
	endproperty
	property p_cur_w;
		s_rd(9'h1AB) |=> reg_rdata_ff == {5'h00, $past(zoom_width)};
	endproperty
	property p_cur_h;
		s_rd(9'h1AC) |=> reg_rdata_ff == {5'h00, $past(zoom_height)};
	endproperty
	property p_classic;
		classic_interp |-> zoom_width == FULL_W && zoom_height == FULL_H;
	endproperty
	property p_hold;
		!(zoom_busy && frame_start) |=> $stable(zoom_width);
	endproperty
	a_out: assert property (p_out) else $error("no zoom out");
	a_in: assert property (p_in) else $error("no zoom in");
	a_rsv: assert property (p_rsv) else $error("reserved set");
	a_cur_w: assert property (p_cur_w) else $error("bad width");
	a_cur_h: assert property (p_cur_h) else $error("bad height");
	a_classic: assert property (p_classic) else $error("classic");
	a_hold: assert property (p_hold) else $error("size moved");
endmodule
`default_nettype wire

// *** sim/irz_zoom_tb_top.sv ***
// Bench for the auto zoom block: register calls and frame pulses.
// Assumes the checker module is compiled first.
`default_nettype none
module irz_zoom_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, sys_rst = 1, frame_start = 0, reg_wr = 0, reg_rd = 0;
	logic [8:0] reg_addr = 9'h000;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata_ff;
	logic [10:0] zoom_width, zoom_height;
	logic [2:0] interp_mode;
	logic classic_interp, zoom_busy;
	int errors = 0, checked = 0;
	always #25 clk = ~clk;
	irz_zoom irz_zoom_inst (.clk, .sys_rst, .frame_start, .reg_addr,
		.reg_wr, .reg_rd, .reg_wdata, .reg_rdata_ff, .zoom_width,
		.zoom_height, .interp_mode, .classic_interp, .zoom_busy);
	task automatic chk(logic [15:0] seen, logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %0t seen %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wr(logic [8:0] a, logic [15:0] d);
		@(negedge clk) reg_wr = 1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk) reg_wr = 0;
	endtask
	task automatic rd(logic [8:0] a, logic [15:0] exp);
		@(negedge clk) reg_rd = 1;
		reg_addr = a;
		@(negedge clk) reg_rd = 0;
		chk(reg_rdata_ff, exp);
	endtask
	task automatic frame;
		@(negedge clk) frame_start = 1;
		@(negedge clk) frame_start = 0;
	endtask
	task automatic wrap_up;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////
	// Whole sequence needs well under 400 cycles
	initial begin
		#50000;
		errors++;
		wrap_up;
	end
	initial begin
		repeat (12) @(negedge clk);
		sys_rst = 0;
		rd(9'h1AE, 16'h0504);
		rd(9'h1AF, 16'h0010);
		chk({13'h0000, interp_mode}, 16'h0001);
		rd(9'h1AB, 16'h0500);
		rd(9'h1AC, 16'h0400);
		wr(9'h1AF, 16'hFEF8);
		rd(9'h1AF, 16'h0278);
		chk({13'h0000, interp_mode}, 16'h0007);
		frame;
		rd(9'h1AF, 16'h0078);
		chk({15'h0000, classic_interp}, 16'h0001);
		wr(9'h1AE, 16'h0A08);
		rd(9'h1AE, 16'h0A08);
		wr(9'h1AF, 16'h0108);
		frame;
		frame;
		rd(9'h1AB, 16'h04EC);
		rd(9'h1AC, 16'h03F0);
		chk({15'h0000, classic_interp}, 16'h0000);
		wr(9'h1AF, 16'h0000);
		frame;
		rd(9'h1AB, 16'h04EC);
		wr(9'h1AF, 16'h0200);
		frame;
		rd(9'h1AB, 16'h04F6);
		frame;
		rd(9'h1AC, 16'h0400);
		rd(9'h1AF, 16'h0000);
		chk({15'h0000, zoom_busy}, 16'h0000);
		wr(9'h1AB, 16'h0123);
		rd(9'h1AB, 16'h0500);
		rd(9'h000, 16'h0000);
		wrap_up;
	end
endmodule
bind irz_zoom irz_zoom_assertions #(.FULL_W(FULL_W), .FULL_H(FULL_H))
	irz_zoom_assertions_inst (.clk, .sys_rst, .frame_start, .reg_addr,
	.reg_wr, .reg_rd, .reg_wdata, .reg_rdata_ff, .zoom_width,
	.zoom_height, .classic_interp, .zoom_busy);
`default_nettype wire
